// File: core/crt_top.v
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "crt_defines.vh"

module crt_top #(
    parameter CODE_W = 6,
    parameter LVL_W  = 10
) (
    // clock and reset
    input  wire             core_clk_i,
    input  wire             rst_n_i,
    // axi4-lite write address
    input  wire [7:0]       s_axi_awaddr_i,
    input  wire [2:0]       s_axi_awprot_i,
    input  wire             s_axi_awvalid_i,
    output wire             s_axi_awready_o,
    // axi4-lite write data
    input  wire [31:0]      s_axi_wdata_i,
    input  wire [3:0]       s_axi_wstrb_i,
    input  wire             s_axi_wvalid_i,
    output wire             s_axi_wready_o,
    // axi4-lite write response
    output reg  [1:0]       s_axi_bresp_o,
    output reg              s_axi_bvalid_o,
    input  wire             s_axi_bready_i,
    // axi4-lite read address
    input  wire [7:0]       s_axi_araddr_i,
    input  wire [2:0]       s_axi_arprot_i,
    input  wire             s_axi_arvalid_i,
    output wire             s_axi_arready_o,
    // axi4-lite read data
    output reg  [31:0]      s_axi_rdata_o,
    output reg  [1:0]       s_axi_rresp_o,
    output reg              s_axi_rvalid_o,
    input  wire             s_axi_rready_i,
    // asynchronous trigger inputs and comparator 3 raw output
    input  wire             ext_int_pin_i,
    input  wire             comparator0_output_i,
    input  wire             cmp3_raw_i,
    // static configuration
    input  wire             dbl_edge_sel_i,
    // comparator reference codes
    output wire [2:0]       cmp2_upper_ref_code_o,
    output wire [2:0]       cmp1_ref_code_o,
    output wire [2:0]       cmp3_ref_code_o,
    output wire [2:0]       cmp2_lower_ref_code_o,
    output wire             cmp3_out_polarity_o,
    // comparator reference levels, thousandths of supply
    output reg  [LVL_W-1:0] cmp2_upper_ref_lvl_o,
    output reg  [LVL_W-1:0] cmp1_ref_lvl_o,
    output reg  [LVL_W-1:0] cmp3_ref_lvl_o,
    output reg  [LVL_W-1:0] cmp2_lower_ref_lvl_o,
    // comparator 3 after polarity control
    output reg              cmp3_out_o,
    // trigger path
    output wire             edge_qualified_trigger_o,
    output wire             pulse_gen_hw_trigger_o,
    output wire             trigger_delay_busy_o
);

    // control registers
    reg  [7:0]        trig_ctrl_q;
    reg  [7:0]        ref_low_q;
    reg  [7:0]        ref_high_q;
    reg  [7:0]        delay_q;

    // input synchronisers
    reg  [1:0]        pin_sync_q;
    reg  [1:0]        cmp0_sync_q;
    reg  [1:0]        cmp3_sync_q;

    // bus decode
    wire              wr_go;
    wire              rd_go;
    reg  [31:0]       rd_data;
    reg               rd_hit;
    reg               wr_hit;

    // trigger path
    wire              pin_debounced;
    wire              debounced_trigger_source;
    wire              delay_busy;

    // turn a 3-bit code into a reference level
    function [LVL_W-1:0] crt_level;
        input [LVL_W-1:0] base;
        input [2:0]       code;
        reg   [LVL_W-1:0] step_sum;
        begin
            step_sum  = `CRT_LVL_STEP * {{(LVL_W-3){1'b0}}, code};
            crt_level = base + step_sum;
        end
    endfunction

    // two-flop synchronisers for pins and analog outputs
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pin_sync_q  <= 2'h0;
            cmp0_sync_q <= 2'h0;
            cmp3_sync_q <= 2'h0;
        end else begin
            pin_sync_q  <= {pin_sync_q[0], ext_int_pin_i};
            cmp0_sync_q <= {cmp0_sync_q[0], comparator0_output_i};
            cmp3_sync_q <= {cmp3_sync_q[0], cmp3_raw_i};
        end
    end

    // both halves taken together, one write outstanding
    assign wr_go           = s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_bvalid_o;
    assign s_axi_awready_o = wr_go;
    assign s_axi_wready_o  = wr_go;
    // one read outstanding
    assign rd_go           = s_axi_arvalid_i & ~s_axi_rvalid_o;
    assign s_axi_arready_o = rd_go;

    // write address decode
    always @* begin
        case (s_axi_awaddr_i)
            `CRT_OFS_TRIG_CTRL: wr_hit = 1'b1;
            `CRT_OFS_REF_LOW:   wr_hit = 1'b1;
            `CRT_OFS_REF_HIGH:  wr_hit = 1'b1;
            `CRT_OFS_DELAY:     wr_hit = 1'b1;
            `CRT_OFS_STATUS:    wr_hit = 1'b1;
            default:            wr_hit = 1'b0;
        endcase
    end

    // register writes through byte lane 0
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            trig_ctrl_q <= `CRT_RST_VAL;
            ref_low_q   <= `CRT_RST_VAL;
            ref_high_q  <= `CRT_RST_VAL;
            delay_q     <= `CRT_RST_VAL;
        end else if (wr_go && s_axi_wstrb_i[0]) begin
            case (s_axi_awaddr_i)
                `CRT_OFS_TRIG_CTRL: trig_ctrl_q <= s_axi_wdata_i[7:0];
                `CRT_OFS_REF_LOW:   ref_low_q   <= {2'h0, s_axi_wdata_i[5:0]};
                `CRT_OFS_REF_HIGH:  ref_high_q  <= {1'b0, s_axi_wdata_i[6:0]};
                `CRT_OFS_DELAY:     delay_q     <= {2'h0, s_axi_wdata_i[5:0]};
                default:            ;
            endcase
        end
    end

    // write response
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `CRT_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? `CRT_RESP_OKAY : `CRT_RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // read mux, upper bits read zero
    always @* begin
        rd_hit  = 1'b1;
        rd_data = 32'h0000_0000;
        case (s_axi_araddr_i)
            `CRT_OFS_TRIG_CTRL: rd_data[7:0] = trig_ctrl_q;
            `CRT_OFS_REF_LOW:   rd_data[7:0] = ref_low_q;
            `CRT_OFS_REF_HIGH:  rd_data[7:0] = ref_high_q;
            `CRT_OFS_DELAY:     rd_data[7:0] = delay_q;
            `CRT_OFS_STATUS:    rd_data[2:0] = {cmp3_out_o, debounced_trigger_source, delay_busy};
            default:            rd_hit       = 1'b0;
        endcase
    end

    // read data channel
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= `CRT_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_data;
            s_axi_rresp_o  <= rd_hit ? `CRT_RESP_OKAY : `CRT_RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    assign cmp2_upper_ref_code_o = ref_low_q[`CRT_CODE_HI_MSB:`CRT_CODE_HI_LSB];
    assign cmp1_ref_code_o       = ref_low_q[`CRT_CODE_LO_MSB:`CRT_CODE_LO_LSB];
    assign cmp3_ref_code_o       = ref_high_q[`CRT_CODE_HI_MSB:`CRT_CODE_HI_LSB];
    assign cmp2_lower_ref_code_o = ref_high_q[`CRT_CODE_LO_MSB:`CRT_CODE_LO_LSB];
    assign cmp3_out_polarity_o   = ref_high_q[`CRT_BIT_CMP3_POL];

    // reference levels and comparator 3 polarity
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cmp2_upper_ref_lvl_o <= {LVL_W{1'b0}};
            cmp1_ref_lvl_o       <= {LVL_W{1'b0}};
            cmp3_ref_lvl_o       <= {LVL_W{1'b0}};
            cmp2_lower_ref_lvl_o <= {LVL_W{1'b0}};
            cmp3_out_o           <= 1'b0;
        end else begin
            cmp2_upper_ref_lvl_o <= crt_level(`CRT_LVL_HIGH_BASE, cmp2_upper_ref_code_o);
            cmp1_ref_lvl_o       <= crt_level(`CRT_LVL_HIGH_BASE, cmp1_ref_code_o);
            if (cmp3_ref_code_o >= `CRT_CMP3_SAT_CODE)
                cmp3_ref_lvl_o <= `CRT_LVL_CMP3_TOP;
            else
                cmp3_ref_lvl_o <= crt_level(`CRT_LVL_HIGH_BASE, cmp3_ref_code_o);
            cmp2_lower_ref_lvl_o <= crt_level(`CRT_LVL_LOW_BASE, cmp2_lower_ref_code_o);
            cmp3_out_o           <= cmp3_sync_q[1] ^ cmp3_out_polarity_o;
        end
    end

    // pin debounce filter
    crt_debounce #(
        .CODE_W (CODE_W)
    ) u_debounce (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .sig_i      (pin_sync_q[1]),
        .code_i     (trig_ctrl_q[CODE_W-1:0]),
        .sig_o      (pin_debounced)
    );

    // select zero pin, one comparator 0
    assign debounced_trigger_source = (trig_ctrl_q[`CRT_BIT_SRC_SEL] ? cmp0_sync_q[1] : pin_debounced)
                                      ^ trig_ctrl_q[`CRT_BIT_INVERT];

    crt_trig_delay #(
        .CODE_W (CODE_W)
    ) u_trig_delay (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .src_i      (debounced_trigger_source),
        .dbl_edge_i (dbl_edge_sel_i),
        .code_i     (delay_q[CODE_W-1:0]),
        .qual_o     (edge_qualified_trigger_o),
        .fire_o     (pulse_gen_hw_trigger_o),
        .busy_o     (delay_busy)
    );

    assign trigger_delay_busy_o = delay_busy;

endmodule // crt_top
`default_nettype wire

// File: core/crt_defines.vh
// Operation
// - reference-low and delay registers: bits 7..6 read zero; every control bit resets to zero
// - reference-low bits 5..3 pick comparator 2 upper reference, 0.600 to 0.775 supply
// - reference-low bits 2..0 pick comparator 1 reference, 0.600 to 0.775 supply, ascending
// - reference-high bit 7 reads zero; bit 6 inverts comparator 3 output when set
// - reference-high bits 5..3 pick comparator 3 reference; codes 110 and 111 both 0.775
// - reference-high bits 2..0 pick comparator 2 lower reference, 0.075 to 0.250 supply
// - delay code counts clock periods up to 101111; codes 11xxxx saturate at 48 periods
// - delay starts at qualified falling edge; hardware trigger issued when it expires
// - qualified falling edges arriving while a delay runs are dropped, never queued
// - trigger source is debounced pin or comparator 0, optionally inverted, then qualified
// - qualified trigger marks a single or a double falling edge of the source
// - source-select zero picks pin, one picks comparator 0; invert bit inverts it
// - pin debounce bypassed for code zero, else needs code periods stable, max 48
`ifndef CRT_DEFINES_VH
`define CRT_DEFINES_VH

// register byte offsets
`define CRT_OFS_TRIG_CTRL    8'h00
`define CRT_OFS_REF_LOW      8'h04
`define CRT_OFS_REF_HIGH     8'h08
`define CRT_OFS_DELAY        8'h0C
`define CRT_OFS_STATUS       8'h10

// reset value shared by all control registers
`define CRT_RST_VAL          8'h00

// field positions
`define CRT_BIT_INVERT       7
`define CRT_BIT_SRC_SEL      6
`define CRT_BIT_CMP3_POL     6
`define CRT_CODE_HI_MSB      5
`define CRT_CODE_HI_LSB      3
`define CRT_CODE_LO_MSB      2
`define CRT_CODE_LO_LSB      0

// reference levels in thousandths of supply
`define CRT_LVL_HIGH_BASE    10'h258
`define CRT_LVL_LOW_BASE     10'h04B
`define CRT_LVL_STEP         10'h019
`define CRT_LVL_CMP3_TOP     10'h307
`define CRT_CMP3_SAT_CODE    3'h6

// timing counts in system clock periods
`define CRT_SAT_CYC          6'h30

// axi responses
`define CRT_RESP_OKAY        2'h0
`define CRT_RESP_SLVERR      2'h2

`endif

// File: core/crt_debounce.v
`timescale 1ns/1ps
`default_nettype none
`include "crt_defines.vh"

module crt_debounce #(
    parameter CODE_W = 6
) (
    // clock and reset
    input  wire              core_clk_i,
    input  wire              rst_n_i,
    // filter
    input  wire              sig_i,
    input  wire [CODE_W-1:0] code_i,
    output reg               sig_o
);

    reg  [CODE_W-1:0] cnt_q;
    wire [CODE_W-1:0] need;
    wire [CODE_W-1:0] cnt_inc;

    assign need    = (code_i > `CRT_SAT_CYC) ? `CRT_SAT_CYC : code_i;
    assign cnt_inc = cnt_q + {{(CODE_W-1){1'b0}}, 1'b1};

    // output follows input once it stays different for need periods
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sig_o <= 1'b0;
            cnt_q <= {CODE_W{1'b0}};
        end else if (code_i == {CODE_W{1'b0}}) begin
            sig_o <= sig_i;
            cnt_q <= {CODE_W{1'b0}};
        end else if (sig_i == sig_o) begin
            cnt_q <= {CODE_W{1'b0}};
        end else if (cnt_inc >= need) begin
            sig_o <= sig_i;
            cnt_q <= {CODE_W{1'b0}};
        end else begin
            cnt_q <= cnt_inc;
        end
    end

endmodule // crt_debounce
`default_nettype wire

// File: core/crt_trig_delay.v
`timescale 1ns/1ps
`default_nettype none
`include "crt_defines.vh"

module crt_trig_delay #(
    parameter CODE_W = 6
) (
    // clock and reset
    input  wire              core_clk_i,
    input  wire              rst_n_i,
    // trigger source and configuration
    input  wire              src_i,
    input  wire              dbl_edge_i,
    input  wire [CODE_W-1:0] code_i,
    // results
    output wire              qual_o,
    output reg               fire_o,
    output reg               busy_o
);

    reg               src_q;
    reg               half_q;
    reg  [CODE_W-1:0] cnt_q;
    wire              fall;
    wire [CODE_W-1:0] dly;

    // single or double falling edge qualification
    assign fall   = src_q & ~src_i;
    assign qual_o = fall & (~dbl_edge_i | half_q);
    assign dly    = (code_i > `CRT_SAT_CYC) ? `CRT_SAT_CYC : code_i;

    // falling-edge history and pair tracking
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            src_q  <= 1'b0;
            half_q <= 1'b0;
        end else begin
            src_q <= src_i;
            if (!dbl_edge_i)
                half_q <= 1'b0;
            else if (fall)
                half_q <= ~half_q;
        end
    end

    // delay counter and trigger pulse
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cnt_q  <= {CODE_W{1'b0}};
            busy_o <= 1'b0;
            fire_o <= 1'b0;
        end else if (busy_o) begin
            cnt_q <= cnt_q - {{(CODE_W-1){1'b0}}, 1'b1};
            if (cnt_q == {{(CODE_W-1){1'b0}}, 1'b1}) begin
                busy_o <= 1'b0;
                fire_o <= 1'b1;
            end else begin
                fire_o <= 1'b0;
            end
        end else if (qual_o) begin
            fire_o <= (dly == {CODE_W{1'b0}});
            busy_o <= (dly > {{(CODE_W-1){1'b0}}, 1'b1});
            cnt_q  <= dly - {{(CODE_W-1){1'b0}}, 1'b1};
            if (dly == {{(CODE_W-1){1'b0}}, 1'b1})
                fire_o <= 1'b1;
        end else begin
            fire_o <= 1'b0;
        end
    end

endmodule // crt_trig_delay
`default_nettype wire

// File: core/crt_dummy_none.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: verif/crt_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module crt_assertions #(
    parameter CODE_W = 6,
    parameter LVL_W  = 10
) (
    // clock and reset
    input wire logic             core_clk_i,
    input wire logic             rst_n_i,
    // bus handshake
    input wire logic             s_axi_awvalid_i,
    input wire logic             s_axi_wvalid_i,
    input wire logic             s_axi_awready_o,
    input wire logic             s_axi_bvalid_o,
    input wire logic [1:0]       s_axi_bresp_o,
    input wire logic             s_axi_rvalid_o,
    input wire logic [31:0]      s_axi_rdata_o,
    // reference codes and levels
    input wire logic [2:0]       cmp2_upper_ref_code_o,
    input wire logic [2:0]       cmp1_ref_code_o,
    input wire logic [2:0]       cmp3_ref_code_o,
    input wire logic [2:0]       cmp2_lower_ref_code_o,
    input wire logic             cmp3_out_polarity_o,
    input wire logic [LVL_W-1:0] cmp2_upper_ref_lvl_o,
    input wire logic [LVL_W-1:0] cmp1_ref_lvl_o,
    input wire logic [LVL_W-1:0] cmp3_ref_lvl_o,
    input wire logic [LVL_W-1:0] cmp2_lower_ref_lvl_o,
    // comparator 3 and trigger path
    input wire logic             cmp3_raw_i,
    input wire logic             cmp3_out_o,
    input wire logic             edge_qualified_trigger_o,
    input wire logic             pulse_gen_hw_trigger_o,
    input wire logic             trigger_delay_busy_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [6:0] busy_run_q;
    // count consecutive busy cycles
    always @(posedge core_clk_i) begin
        if (!rst_n_i || !trigger_delay_busy_o) busy_run_q <= 7'h0;
        else busy_run_q <= busy_run_q + 7'h1;
    end
    a_rdata_upper_zero: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_lvl_cmp2_upper: assert property (rst_n_i && $past(rst_n_i) |->
        cmp2_upper_ref_lvl_o == 10'h258 + 10'h019 * $past(cmp2_upper_ref_code_o)) else $error("cmp2 upper level");
    a_lvl_cmp1: assert property (rst_n_i && $past(rst_n_i) |->
        cmp1_ref_lvl_o == 10'h258 + 10'h019 * $past(cmp1_ref_code_o)) else $error("cmp1 level");
    a_lvl_cmp3: assert property (rst_n_i && $past(rst_n_i) |-> cmp3_ref_lvl_o ==
        ($past(cmp3_ref_code_o) >= 3'h6 ? 10'h307 : 10'h258 + 10'h019 * $past(cmp3_ref_code_o)))
        else $error("cmp3 level");
    a_lvl_cmp2_lower: assert property (rst_n_i && $past(rst_n_i) |->
        cmp2_lower_ref_lvl_o == 10'h04B + 10'h019 * $past(cmp2_lower_ref_code_o)) else $error("cmp2 lower level");
    a_cmp3_pol_out: assert property (($stable(cmp3_raw_i) && $stable(cmp3_out_polarity_o)) [*5] |->
        cmp3_out_o == (cmp3_raw_i ^ cmp3_out_polarity_o)) else $error("cmp3 output polarity");
    a_fire_cause: assert property (pulse_gen_hw_trigger_o |->
        $past(trigger_delay_busy_o) || $past(edge_qualified_trigger_o)) else $error("trigger without cause");
    a_busy_fall_fire: assert property ($fell(trigger_delay_busy_o) |-> pulse_gen_hw_trigger_o)
        else $error("busy ended without trigger");
    a_busy_run_bound: assert property (busy_run_q <= 7'h2F)
        else $error("delay ran too long");
    a_write_answer: assert property (s_axi_awvalid_i && s_axi_wvalid_i && s_axi_awready_o |=> s_axi_bvalid_o)
        else $error("write not answered");
    c_fire: cover property (pulse_gen_hw_trigger_o);
    c_qual_busy: cover property (edge_qualified_trigger_o && trigger_delay_busy_o);
    c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
endmodule // crt_assertions
bind crt_top crt_assertions #(.CODE_W(CODE_W), .LVL_W(LVL_W)) crt_assertions_i (.core_clk_i, .rst_n_i,
    .s_axi_awvalid_i, .s_axi_wvalid_i, .s_axi_awready_o, .s_axi_bvalid_o, .s_axi_bresp_o, .s_axi_rvalid_o,
    .s_axi_rdata_o, .cmp2_upper_ref_code_o, .cmp1_ref_code_o, .cmp3_ref_code_o, .cmp2_lower_ref_code_o,
    .cmp3_out_polarity_o, .cmp2_upper_ref_lvl_o, .cmp1_ref_lvl_o, .cmp3_ref_lvl_o, .cmp2_lower_ref_lvl_o,
    .cmp3_raw_i, .cmp3_out_o, .edge_qualified_trigger_o, .pulse_gen_hw_trigger_o, .trigger_delay_busy_o);
`default_nettype wire

// File: verif/crt_pg_model.sv
`timescale 1ns/1ps
`default_nettype none
module crt_pg_model (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // pulses from the block
    input  wire logic trig_i,
    input  wire logic qual_i,
    // event counts
    output var int    fires_o,
    output var int    quals_o
);
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            fires_o <= 0;
            quals_o <= 0;
        end else begin
            fires_o <= fires_o + ((trig_i === 1'b1) ? 1 : 0);
            quals_o <= quals_o + ((qual_i === 1'b1) ? 1 : 0);
        end
    end
endmodule // crt_pg_model
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "crt_defines.vh"
module tb_top;
    // driven inputs
    logic core_clk_i = 0, rst_n_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
    logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, ext_int_pin_i = 0, comparator0_output_i = 0;
    logic cmp3_raw_i = 0, dbl_edge_sel_i = 0;
    logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
    logic [2:0] s_axi_awprot_i = 0, s_axi_arprot_i = 0;
    logic [31:0] s_axi_wdata_i = 0;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    // design outputs
    wire logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    wire logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    wire logic [31:0] s_axi_rdata_o;
    wire logic [2:0] cmp2_upper_ref_code_o, cmp1_ref_code_o, cmp3_ref_code_o, cmp2_lower_ref_code_o;
    wire logic [9:0] cmp2_upper_ref_lvl_o, cmp1_ref_lvl_o, cmp3_ref_lvl_o, cmp2_lower_ref_lvl_o;
    wire logic cmp3_out_polarity_o, cmp3_out_o, edge_qualified_trigger_o, pulse_gen_hw_trigger_o;
    wire logic trigger_delay_busy_o;
    int mismatches = 0, num_checks = 0, fires, quals;
    crt_top crt_top_i (.core_clk_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awprot_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
        .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arprot_i, .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .ext_int_pin_i, .comparator0_output_i,
        .cmp3_raw_i, .dbl_edge_sel_i, .cmp2_upper_ref_code_o, .cmp1_ref_code_o, .cmp3_ref_code_o,
        .cmp2_lower_ref_code_o, .cmp3_out_polarity_o, .cmp2_upper_ref_lvl_o, .cmp1_ref_lvl_o, .cmp3_ref_lvl_o,
        .cmp2_lower_ref_lvl_o, .cmp3_out_o, .edge_qualified_trigger_o, .pulse_gen_hw_trigger_o,
        .trigger_delay_busy_o);
    crt_pg_model crt_pg_model_i (.core_clk_i, .rst_n_i, .trig_i(pulse_gen_hw_trigger_o),
        .qual_i(edge_qualified_trigger_o), .fires_o(fires), .quals_o(quals));
    // clock
    initial forever #5 core_clk_i = ~core_clk_i;
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // one edge of a bounded wait
    task automatic tick(inout int n);
        @(posedge core_clk_i);
        n++;
        if (n > 200) begin
            mismatches++;
            final_report;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        do tick(n); while (s_axi_awready_o !== 1'b1 || s_axi_wready_o !== 1'b1);
        s_axi_awvalid_i <= 1'b0;
        s_axi_wvalid_i <= 1'b0;
        s_axi_bready_i <= 1'b1;
        do tick(n); while (s_axi_bvalid_o !== 1'b1);
        r = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        do tick(n); while (s_axi_arready_o !== 1'b1);
        s_axi_arvalid_i <= 1'b0;
        s_axi_rready_i <= 1'b1;
        do tick(n); while (s_axi_rvalid_o !== 1'b1);
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
    endtask
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 4; i++) begin
            rd(8'(4 * i), d, r);
            chk("reset value", d, 32'h0);
        end
    endtask
    task automatic t_ref_low;
        logic [31:0] d;
        logic [1:0] r;
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(`CRT_OFS_REF_LOW, {26'h3FFFFFF, c, ~c}, r);
            chk("bresp", r, `CRT_RESP_OKAY);
            rd(`CRT_OFS_REF_LOW, d, r);
            chk("ref low", d, {26'h0, c, ~c});
            chk("low codes", {cmp2_upper_ref_code_o, cmp1_ref_code_o}, {c, ~c});
            chk("cmp2 upper lvl", cmp2_upper_ref_lvl_o, 32'h258 + 32'h19 * i);
            chk("cmp1 lvl", cmp1_ref_lvl_o, 32'h258 + 32'h19 * (7 - i));
        end
    endtask
    task automatic t_ref_high;
        logic [31:0] d;
        logic [1:0] r;
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(`CRT_OFS_REF_HIGH, {25'h1FFFFFF, c[0], c, c}, r);
            rd(`CRT_OFS_REF_HIGH, d, r);
            cmp3_raw_i <= c[1];
            chk("ref high", d, {25'h0, c[0], c, c});
            chk("high codes", {cmp3_out_polarity_o, cmp3_ref_code_o, cmp2_lower_ref_code_o}, {c[0], c, c});
            chk("cmp3 lvl", cmp3_ref_lvl_o, (i > 5) ? 32'h307 : 32'h258 + 32'h19 * i);
            chk("cmp2 lower lvl", cmp2_lower_ref_lvl_o, 32'h4B + 32'h19 * i);
            repeat (6) @(posedge core_clk_i);
            chk("cmp3 out", cmp3_out_o, c[1] ^ c[0]);
        end
    endtask
    task automatic t_unmapped;
        logic [31:0] d;
        logic [1:0] r;
        wr(8'h14, 32'hFF, r);
        chk("unmapped bresp", r, `CRT_RESP_SLVERR);
        rd(8'h14, d, r);
        chk("unmapped rresp", r, `CRT_RESP_SLVERR);
        chk("unmapped rdata", d, 32'h0);
    endtask
    // delay from a qualified fall, with a second fall while it runs when exp is above 8
    task automatic t_delay(input logic [7:0] code, input int exp);
        logic [31:0] d;
        logic [1:0] r;
        int n, k, f0;
        wr(`CRT_OFS_DELAY, {24'h0, code}, r);
        rd(`CRT_OFS_DELAY, d, r);
        chk("delay reg", d, {26'h0, code[5:0]});
        comparator0_output_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        comparator0_output_i <= 1'b0;
        n = 0;
        do tick(n); while (edge_qualified_trigger_o !== 1'b1);
        f0 = fires;
        k = 0;
        comparator0_output_i <= 1'b1;
        do begin
            tick(n);
            k++;
            if (k == 3 && exp > 8) comparator0_output_i <= 1'b0;
        end while (pulse_gen_hw_trigger_o !== 1'b1);
        chk("delay cycles", k, exp);
        repeat (8) @(posedge core_clk_i);
        chk("trigger count", fires - f0, 1);
    endtask
    task automatic blip(input bit pin, input int hi);
        if (pin) ext_int_pin_i <= 1'b1;
        else comparator0_output_i <= 1'b1;
        repeat (hi) @(posedge core_clk_i);
        ext_int_pin_i <= 1'b0;
        comparator0_output_i <= 1'b0;
        repeat (12) @(posedge core_clk_i);
    endtask
    task automatic t_double;
        logic [1:0] r;
        int q0;
        dbl_edge_sel_i <= 1'b1;
        wr(`CRT_OFS_DELAY, 32'h0, r);
        q0 = quals;
        blip(0, 4);
        chk("first fall", quals - q0, 0);
        blip(0, 4);
        chk("second fall", quals - q0, 1);
        dbl_edge_sel_i <= 1'b0;
    endtask
    task automatic t_pin;
        logic [31:0] d;
        logic [1:0] r;
        int q0;
        wr(`CRT_OFS_TRIG_CTRL, 32'h84, r);
        q0 = quals;
        blip(0, 4);
        chk("unselected source", quals - q0, 0);
        blip(1, 2);
        chk("pin glitch", quals - q0, 0);
        blip(1, 10);
        chk("inverted pin", quals - q0, 1);
        // idle pin low reads back as a high source only when inverted
        rd(`CRT_OFS_STATUS, d, r);
        chk("status", d, 32'h2);
    endtask
    // main sequence
    initial begin
        logic [1:0] r;
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        t_reset;
        t_ref_low;
        t_ref_high;
        t_unmapped;
        wr(`CRT_OFS_TRIG_CTRL, 32'h40, r);
        t_delay(8'h00, 1);
        t_delay(8'h01, 1);
        t_delay(8'h02, 2);
        t_delay(8'h2F, 47);
        t_delay(8'h30, 48);
        t_delay(8'hFF, 48);
        t_double;
        t_pin;
        final_report;
    end
endmodule // tb_top
`default_nettype wire
